// ==== common/vic_pkg.sv ====
// package for the vectored interrupt controller: offsets, layouts, vectors and states
package vic_pkg;
	localparam int unsigned VIC_SRC_COUNT = 14;
	localparam logic [3:0] VIC_IDX_OSD = 4'h0;
	localparam logic [3:0] VIC_IDX_EXT_ONE = 4'h1;
	localparam logic [3:0] VIC_IDX_SLICER = 4'h2;
	localparam logic [3:0] VIC_IDX_SERIAL = 4'h3;
	localparam logic [3:0] VIC_IDX_TIMER4 = 4'h4;
	localparam logic [3:0] VIC_IDX_PERIODIC = 4'h5;
	localparam logic [3:0] VIC_IDX_VSYNC = 4'h6;
	localparam logic [3:0] VIC_IDX_TIMER3 = 4'h7;
	localparam logic [3:0] VIC_IDX_TIMER2 = 4'h8;
	localparam logic [3:0] VIC_IDX_TIMER1 = 4'h9;
	localparam logic [3:0] VIC_IDX_ADC_EXT3 = 4'ha;
	localparam logic [3:0] VIC_IDX_EXT_TWO = 4'hb;
	localparam logic [3:0] VIC_IDX_TWOWIRE = 4'hc;
	localparam logic [3:0] VIC_IDX_TIMER56 = 4'hd;
	// register byte offsets
	localparam logic [7:0] VIC_OFS_REQUEST1 = 8'h00;
	localparam logic [7:0] VIC_OFS_REQUEST2 = 8'h04;
	localparam logic [7:0] VIC_OFS_CONTROL1 = 8'h08;
	localparam logic [7:0] VIC_OFS_CONTROL2 = 8'h0c;
	localparam logic [7:0] VIC_OFS_POLARITY = 8'h10;
	localparam logic [7:0] VIC_OFS_TIMER_SEL = 8'h14;
	// polarity / selection register fields
	localparam int unsigned VIC_POL_EXT_ONE_BIT = 3;
	localparam int unsigned VIC_POL_EXT_TWO_BIT = 4;
	localparam int unsigned VIC_POL_EXT_THREE_BIT = 6;
	localparam int unsigned VIC_SEL_EXT3_BIT = 7;
	localparam logic [7:0] VIC_POLARITY_MASK = 8'hd8;
	localparam logic [7:0] VIC_POLARITY_RESET = 8'h00;
	localparam logic VIC_TIMER_SEL_RESET = 1'b0;
	// vectors (address of the low byte of each pair)
	localparam logic [15:0] VIC_VEC_RESET = 16'hfffe;
	localparam logic [15:0] VIC_VEC_BREAK = 16'hffde;
	localparam logic [15:0] VIC_VEC_STEP = 16'h0002;
	// periodic request interval in main oscillator cycles
	localparam int unsigned VIC_OSC_PERIOD = 4096;
	localparam logic [11:0] VIC_OSC_LAST = 12'(VIC_OSC_PERIOD - 1);

	typedef enum logic [3:0] {
		VIC_ST_IDLE = 4'b0001,
		VIC_ST_PUSH = 4'b0010,
		VIC_ST_MASK = 4'b0100,
		VIC_ST_LOAD = 4'b1000
	} vic_state_type;

	typedef struct packed {
		logic onscreen_display_done;
		logic vsync_event;
		logic slicer_done;
		logic serial_done;
		logic adc_done;
		logic twowire_event;
		logic timer1_overflow;
		logic timer2_overflow;
		logic timer3_overflow;
		logic timer4_overflow;
		logic timer5_overflow;
		logic timer6_overflow;
	} vic_events_type;

	typedef struct packed {
		logic ext_irq_one;
		logic ext_irq_two;
		logic ext_irq_three;
	} vic_pins_type;
endpackage

// ==== core/vic_controller.sv ====
// vectored fixed-priority interrupt controller with apb register access
// Behaviour
// RULE1: eighteen sources: reset, four external, twelve internal events, one break instruction; the code has three external pins and thirteen internal sources.
// RULE2: fixed ranking from reset down to break, sixteen priority levels.
// RULE3: vector pairs step down two bytes per level; break uses ffdf/ffde.
// RULE4: acceptance first requests a push of program counter and status.
// RULE5: acceptance then sets the disable flag and clears the accepted request.
// RULE6: last, the program counter is loaded from the selected vector.
// RULE7: each source except break has request and enable bits in two register pairs; the code gives reset neither.
// RULE8: maskable source taken only with enable set, request set, disable flag clear.
// RULE9: software may clear request bits but never set them.
// RULE10: software writes enable bits freely.
// RULE11: reset acts as top priority interrupt ignoring enables and disable flag.
// RULE12: break is lowest priority, has no enable, ignores the disable flag.
// RULE13: external inputs request on an edge chosen by polarity bits 3, 4, 6.
// RULE14: converter done and external three share a vector, chosen by bit 7.
// RULE15: timer five and six overflows share one vector, chosen by software.
// RULE16: software picks shared sources only at initialization to avoid spurious requests.
// RULE17: periodic request every 4096 oscillator cycles while pwm mode bit 0 is zero.
// RULE18: overflow of timers one to four sets that timer's own request bit.
// RULE19: display done event raises the display request.
// RULE20: vertical sync event raises the vertical sync request.
// RULE21: slicer done and converter done raise their requests.
// RULE22: among pending enabled requests the lowest priority number wins; others stay pending.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module vic_controller (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// event sources
	input wire vic_pkg::vic_events_type events,
	input wire vic_pkg::vic_pins_type pins,
	input wire logic pwm_mode_bit0,
	// cpu core side
	input wire logic cpu_disable_flag,
	input wire logic break_instruction,
	output logic irq_pending,
	output logic push_req,
	input wire logic push_done,
	output logic set_disable,
	output logic load_req,
	output logic [15:0] vector_addr,
	input wire logic load_done
);

	vic_pkg::vic_state_type state;
	logic [vic_pkg::VIC_SRC_COUNT-1:0] request;
	logic [vic_pkg::VIC_SRC_COUNT-1:0] enable;
	logic [vic_pkg::VIC_SRC_COUNT-1:0] set_req;
	logic [vic_pkg::VIC_SRC_COUNT-1:0] clr_req;
	logic [vic_pkg::VIC_SRC_COUNT-1:0] ready_req;
	logic [7:0] polarity;
	logic timer_sel;
	logic break_pend;
	logic reset_pend;
	vic_pkg::vic_pins_type pins_prev;
	logic [2:0] ext_edge;
	logic [11:0] osc_count;
	logic periodic_tick;
	logic adc_prev_sel;
	logic win_valid;
	logic win_break;
	logic [3:0] win_index;
	logic [15:0] win_vector;
	logic [3:0] taken_index;
	logic taken_break;
	logic wr_access;
	logic rd_setup;
	logic addr_ok;
	logic [31:0] next_prdata;
	logic wr_req1;
	logic wr_req2;
	logic wr_ctl1;
	logic wr_ctl2;
	logic wr_pol;
	logic wr_tsel;
	logic [2:0] pin_now;
	logic [2:0] pin_old;
	logic [2:0] pin_fall;

	// apb decode: zero wait states, read data captured in the setup phase
	assign pready = 1'b1;
	assign wr_access = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;

	// one write strobe per register keeps the address compare in a single place
	assign wr_req1 = wr_access && paddr == vic_pkg::VIC_OFS_REQUEST1;
	assign wr_req2 = wr_access && paddr == vic_pkg::VIC_OFS_REQUEST2;
	assign wr_ctl1 = wr_access && paddr == vic_pkg::VIC_OFS_CONTROL1;
	assign wr_ctl2 = wr_access && paddr == vic_pkg::VIC_OFS_CONTROL2;
	assign wr_pol = wr_access && paddr == vic_pkg::VIC_OFS_POLARITY;
	assign wr_tsel = wr_access && paddr == vic_pkg::VIC_OFS_TIMER_SEL;

	always_comb begin
		addr_ok = 1'b1;
		next_prdata = 32'h0000_0000;
		if (paddr == vic_pkg::VIC_OFS_REQUEST1) begin
			next_prdata[7:0] = request[7:0];
		end else if (paddr == vic_pkg::VIC_OFS_REQUEST2) begin
			next_prdata[5:0] = request[13:8];
		end else if (paddr == vic_pkg::VIC_OFS_CONTROL1) begin
			next_prdata[7:0] = enable[7:0];
		end else if (paddr == vic_pkg::VIC_OFS_CONTROL2) begin
			next_prdata[5:0] = enable[13:8];
		end else if (paddr == vic_pkg::VIC_OFS_POLARITY) begin
			next_prdata[7:0] = polarity;
		end else if (paddr == vic_pkg::VIC_OFS_TIMER_SEL) begin
			next_prdata[0] = timer_sel;
		end else begin
			addr_ok = 1'b0;
		end
	end

	assign pslverr = psel & penable & ~addr_ok;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= next_prdata;
		end
	end

	// enable bits, written directly
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			enable <= '0;
		end else if (wr_ctl1) begin
			enable[7:0] <= pwdata[7:0]; // [RULE7] [RULE10]
		end else if (wr_ctl2) begin
			enable[13:8] <= pwdata[5:0]; // [RULE7] [RULE10]
		end
	end

	// polarity and shared-source selection; changing these live cannot fake an edge
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			polarity <= vic_pkg::VIC_POLARITY_RESET; // [RULE13]
			timer_sel <= vic_pkg::VIC_TIMER_SEL_RESET;
		end else if (wr_pol) begin
			polarity <= pwdata[7:0] & vic_pkg::VIC_POLARITY_MASK; // [RULE14]
		end else if (wr_tsel) begin
			timer_sel <= pwdata[0]; // [RULE15] [RULE16]
		end
	end

	// external edge detection: zero selects rising, one selects falling
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pins_prev <= '0;
		end else begin
			pins_prev <= pins;
		end
	end

	// pins and their polarity bits as vectors, so one loop serves all three
	assign pin_now = {pins.ext_irq_three, pins.ext_irq_two, pins.ext_irq_one};
	assign pin_old = {pins_prev.ext_irq_three, pins_prev.ext_irq_two, pins_prev.ext_irq_one};
	assign pin_fall[0] = polarity[vic_pkg::VIC_POL_EXT_ONE_BIT];
	assign pin_fall[1] = polarity[vic_pkg::VIC_POL_EXT_TWO_BIT];
	assign pin_fall[2] = polarity[vic_pkg::VIC_POL_EXT_THREE_BIT];

	// a pin held high through reset shows a rising edge right after release
	genvar ge;
	generate
		for (ge = 0; ge < 3; ge++) begin : g_edge
			assign ext_edge[ge] = pin_fall[ge] ? (pin_old[ge] & ~pin_now[ge])
				: (~pin_old[ge] & pin_now[ge]); // [RULE13]
		end
	endgenerate

	// periodic divider of the main oscillator, cleared while the pwm mode bit is set
	always_ff @(posedge sys_clk) begin
		if (reset || pwm_mode_bit0) begin
			osc_count <= 12'h000;
		end else begin
			osc_count <= osc_count + 12'h001; // [RULE17]
		end
	end

	assign periodic_tick = ~pwm_mode_bit0 && osc_count == vic_pkg::VIC_OSC_LAST; // [RULE17]

	// selection delayed one cycle; a live flip cannot fake a request, only event pulses set it
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			adc_prev_sel <= 1'b0;
		end else begin
			adc_prev_sel <= polarity[vic_pkg::VIC_SEL_EXT3_BIT];
		end
	end

	// hardware set sources, one bit per maskable priority level
	always_comb begin
		set_req = '0;
		set_req[vic_pkg::VIC_IDX_OSD] = events.onscreen_display_done; // [RULE19]
		set_req[vic_pkg::VIC_IDX_EXT_ONE] = ext_edge[0];
		set_req[vic_pkg::VIC_IDX_SLICER] = events.slicer_done; // [RULE21]
		set_req[vic_pkg::VIC_IDX_SERIAL] = events.serial_done;
		set_req[vic_pkg::VIC_IDX_TIMER4] = events.timer4_overflow; // [RULE18]
		set_req[vic_pkg::VIC_IDX_PERIODIC] = periodic_tick; // [RULE17]
		set_req[vic_pkg::VIC_IDX_VSYNC] = events.vsync_event; // [RULE20]
		set_req[vic_pkg::VIC_IDX_TIMER3] = events.timer3_overflow; // [RULE18]
		set_req[vic_pkg::VIC_IDX_TIMER2] = events.timer2_overflow; // [RULE18]
		set_req[vic_pkg::VIC_IDX_TIMER1] = events.timer1_overflow; // [RULE18]
		set_req[vic_pkg::VIC_IDX_ADC_EXT3] = adc_prev_sel ? ext_edge[2] : events.adc_done; // [RULE14] [RULE21]
		set_req[vic_pkg::VIC_IDX_EXT_TWO] = ext_edge[1];
		set_req[vic_pkg::VIC_IDX_TWOWIRE] = events.twowire_event;
		set_req[vic_pkg::VIC_IDX_TIMER56] = timer_sel ? events.timer6_overflow : events.timer5_overflow; // [RULE15]
	end

	// clears: a written zero or the acceptance of that source
	always_comb begin
		clr_req = '0;
		if (wr_req1) begin
			clr_req[7:0] = ~pwdata[7:0]; // [RULE9]
		end else if (wr_req2) begin
			clr_req[13:8] = ~pwdata[5:0]; // [RULE9]
		end
		if (state == vic_pkg::VIC_ST_MASK && !taken_break) begin
			clr_req[taken_index] = 1'b1; // [RULE5]
		end
	end

	// set wins over clear so an event in the clearing cycle survives
	genvar gi;
	generate
		for (gi = 0; gi < vic_pkg::VIC_SRC_COUNT; gi++) begin : g_req
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					request[gi] <= 1'b0;
				end else begin
					request[gi] <= set_req[gi] | (request[gi] & ~clr_req[gi]); // [RULE7] [RULE9]
				end
			end
		end
	endgenerate

	// break pending until the mask step of its acceptance
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			break_pend <= 1'b0;
		end else if (break_instruction) begin
			break_pend <= 1'b1;
		end else if (state == vic_pkg::VIC_ST_MASK && taken_break) begin
			break_pend <= 1'b0;
		end
	end

	// priority resolution: lowest index wins, break only when nothing maskable is ready
	assign ready_req = request & enable & {vic_pkg::VIC_SRC_COUNT{~cpu_disable_flag}}; // [RULE8]

	always_comb begin
		win_valid = 1'b0;
		win_break = 1'b0;
		win_index = 4'h0;
		for (int i = vic_pkg::VIC_SRC_COUNT - 1; i >= 0; i--) begin
			if (ready_req[i]) begin
				win_valid = 1'b1;
				win_index = 4'(i); // [RULE22] [RULE2]
			end
		end
		if (!win_valid && break_pend) begin
			win_valid = 1'b1;
			win_break = 1'b1; // [RULE12]
		end
	end

	always_comb begin
		if (win_break) begin
			win_vector = vic_pkg::VIC_VEC_BREAK; // [RULE3]
		end else begin
			win_vector = vic_pkg::VIC_VEC_RESET - vic_pkg::VIC_VEC_STEP * (16'(win_index) + 16'h0001); // [RULE3]
		end
	end

	assign irq_pending = win_valid;

	// winner captured as the sequence starts; reset forces the reset vector
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			taken_index <= 4'h0;
			taken_break <= 1'b0;
			vector_addr <= vic_pkg::VIC_VEC_RESET; // [RULE11]
		end else if (state == vic_pkg::VIC_ST_IDLE && win_valid) begin
			taken_index <= win_index;
			taken_break <= win_break;
			vector_addr <= win_vector; // [RULE3]
		end
	end

	// the reset fetch keeps the disable flag raised for its whole load
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reset_pend <= 1'b1;
		end else if (state == vic_pkg::VIC_ST_LOAD && load_done) begin
			reset_pend <= 1'b0;
		end
	end

	// acceptance sequence: push, mask, load; reset skips straight to load
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state <= vic_pkg::VIC_ST_LOAD; // [RULE11]
		end else begin
			case (state)
				vic_pkg::VIC_ST_IDLE: begin
					if (win_valid) begin
						state <= vic_pkg::VIC_ST_PUSH; // [RULE1]
					end
				end
				vic_pkg::VIC_ST_PUSH: begin
					if (push_done) begin
						state <= vic_pkg::VIC_ST_MASK; // [RULE4]
					end
				end
				vic_pkg::VIC_ST_MASK: begin
					state <= vic_pkg::VIC_ST_LOAD; // [RULE5]
				end
				vic_pkg::VIC_ST_LOAD: begin
					if (load_done) begin
						state <= vic_pkg::VIC_ST_IDLE; // [RULE6]
					end
				end
				default: begin
					state <= vic_pkg::VIC_ST_IDLE;
				end
			endcase
		end
	end

	assign push_req = state == vic_pkg::VIC_ST_PUSH; // [RULE4]
	assign set_disable = state == vic_pkg::VIC_ST_MASK || (state == vic_pkg::VIC_ST_LOAD && reset_pend); // [RULE5]
	assign load_req = state == vic_pkg::VIC_ST_LOAD; // [RULE6]

endmodule // vic_controller

// ==== verification/vic_monitor.sv ====
// assertions on the interrupt controller ports
`timescale 1ns/100ps
module vic_monitor (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// sources
	input wire vic_pkg::vic_events_type events,
	input wire vic_pkg::vic_pins_type pins,
	input wire logic pwm_mode_bit0,
	// cpu side
	input wire logic cpu_disable_flag,
	input wire logic break_instruction,
	input wire logic irq_pending,
	input wire logic push_req,
	input wire logic push_done,
	input wire logic set_disable,
	input wire logic load_req,
	input wire logic [15:0] vector_addr,
	input wire logic load_done
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	a_push_follows: assert property (irq_pending && !push_req && !set_disable && !load_req |=> push_req)
		else $error("no push after pending");
	a_push_holds: assert property (push_req && !push_done |=> push_req)
		else $error("push dropped");
	a_mask_then_load: assert property (push_req && push_done |=> set_disable && !push_req ##1 load_req)
		else $error("bad acceptance order");
	a_load_holds: assert property (load_req && !load_done |=> load_req && $stable(vector_addr))
		else $error("load dropped");
	a_disable_pulse: assert property (set_disable && !load_req |=> !set_disable)
		else $error("disable not one cycle");
	a_vector_legal: assert property ($rose(push_req) |-> vector_addr == vic_pkg::VIC_VEC_BREAK ||
		(vector_addr[0] == 1'b0 && vector_addr inside {[16'hffe2:16'hfffc]})) else $error("bad vector");
	a_flag_masks: assert property ($rose(push_req) && $past(cpu_disable_flag) |->
		vector_addr == vic_pkg::VIC_VEC_BREAK) else $error("masked source taken");
	a_unmapped_err: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
		else $error("no error on unmapped");
	a_reset_vector: assert property (disable iff (1'b0) reset |=> load_req && vector_addr == 16'hfffe)
		else $error("no reset vector");
	c_break: cover property ($rose(load_req) && vector_addr == vic_pkg::VIC_VEC_BREAK);
	c_slow_push: cover property (push_req [*3] ##1 push_done);
	c_error: cover property (pslverr);
endmodule // vic_monitor

// ==== verification/vic_cpu_model.sv ====
// behavioural cpu core answering the acceptance handshake
`timescale 1ns/100ps
module vic_cpu_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// controller side
	input wire logic push_req,
	input wire logic set_disable,
	input wire logic load_req,
	output logic push_done,
	output logic load_done,
	output logic cpu_disable_flag,
	// bench control
	input wire logic slow,
	input wire logic rti
);
	logic [1:0] wait_cnt;
	always_ff @(posedge sys_clk) begin
		if (reset || push_done || load_done || !(push_req || load_req))
			wait_cnt <= 2'h0;
		else
			wait_cnt <= wait_cnt + 2'h1;
	end
	// a slow core answers in the fourth cycle of a request
	assign push_done = push_req && (!slow || wait_cnt == 2'h3);
	assign load_done = load_req && (!slow || wait_cnt == 2'h3);
	// flag stays up until the bench models a return from interrupt
	always_ff @(posedge sys_clk) begin
		if (reset || set_disable)
			cpu_disable_flag <= 1'b1;
		else if (rti)
			cpu_disable_flag <= 1'b0;
	end
endmodule // vic_cpu_model

// ==== verification/tb.sv ====
// testbench for the interrupt controller
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("Error %0t: %h not %h", $time, a, b); end end
module tb;
	logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, pwm_mode_bit0, break_instruction;
	logic irq_pending, push_req, push_done, set_disable, load_req, load_done, cpu_disable_flag, slow, rti;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] vector_addr;
	vic_pkg::vic_events_type events;
	vic_pkg::vic_pins_type pins;
	int error_cnt = 0;
	int n_tests = 0;
	time t_load;
	vic_controller i_vic_controller (.*);
	vic_cpu_model i_vic_cpu_model (.*);
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	// expectation carries the error flag above the data word
	task automatic rd(input logic [7:0] a, input logic [32:0] x);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		`CHK({e, q}, x)
	endtask
	task automatic pulse(input logic [11:0] e, input logic [2:0] p, input logic b);
		events <= e;
		pins <= p;
		break_instruction <= b;
		@(posedge sys_clk);
		events <= 12'h000;
		break_instruction <= 1'b0;
		@(posedge sys_clk);
	endtask
	// return from the last interrupt, then wait for the next vector fetch
	task automatic take(input logic [15:0] v);
		int n;
		rti <= 1'b1;
		@(posedge sys_clk);
		rti <= 1'b0;
		for (n = 0; n < 5000 && !(load_req === 1'b1 && load_done === 1'b1); n++)
			@(posedge sys_clk);
		t_load = $time;
		`CHK({load_done, vector_addr}, {1'b1, v})
		@(posedge sys_clk);
	endtask
	task automatic t_reset;
		`CHK({load_req, vector_addr}, {1'b1, vic_pkg::VIC_VEC_RESET})
		reset <= 1'b0;
		rd(vic_pkg::VIC_OFS_POLARITY, 33'h0);
		rd(vic_pkg::VIC_OFS_CONTROL1, 33'h0);
		rd(8'h40, 33'h100000000);
		wr(vic_pkg::VIC_OFS_REQUEST1, 32'hff);
		rd(vic_pkg::VIC_OFS_REQUEST1, 33'h0);
		wr(vic_pkg::VIC_OFS_CONTROL2, 32'h3f);
		rd(vic_pkg::VIC_OFS_CONTROL2, 33'h3f);
	endtask
	task automatic t_break;
		slow <= 1'b1;
		pulse(12'h000, 3'b000, 1'b1);
		take(vic_pkg::VIC_VEC_BREAK);
	endtask
	task automatic t_priority;
		pulse(12'hffe, 3'b110, 1'b0);
		`CHK(irq_pending, 1'b0)
		rd(vic_pkg::VIC_OFS_REQUEST1, 33'h0df);
		rd(vic_pkg::VIC_OFS_REQUEST2, 33'h03f);
		wr(vic_pkg::VIC_OFS_CONTROL1, 32'hff);
		`CHK(irq_pending, 1'b0)
		for (int i = 0; i < 14; i++)
			if (i != 5)
				take(16'hfffc - 16'(2 * i));
		rd(vic_pkg::VIC_OFS_REQUEST1, 33'h0);
		rd(vic_pkg::VIC_OFS_REQUEST2, 33'h0);
	endtask
	task automatic t_edges;
		wr(vic_pkg::VIC_OFS_POLARITY, 32'h08);
		pulse(12'h000, 3'b000, 1'b0);
		rd(vic_pkg::VIC_OFS_REQUEST1, 33'h002);
		rd(vic_pkg::VIC_OFS_REQUEST2, 33'h0);
		wr(vic_pkg::VIC_OFS_REQUEST1, 32'h0);
		rd(vic_pkg::VIC_OFS_REQUEST1, 33'h0);
	endtask
	// sources are switched while masked and the request is cleared afterwards
	task automatic t_shared;
		wr(vic_pkg::VIC_OFS_POLARITY, 32'h88);
		wr(vic_pkg::VIC_OFS_TIMER_SEL, 32'h1);
		wr(vic_pkg::VIC_OFS_REQUEST2, 32'h0);
		pulse(12'h082, 3'b000, 1'b0);
		rd(vic_pkg::VIC_OFS_REQUEST2, 33'h0);
		pulse(12'h001, 3'b001, 1'b0);
		rd(vic_pkg::VIC_OFS_REQUEST2, 33'h024);
	endtask
	task automatic t_periodic;
		time t0;
		wr(vic_pkg::VIC_OFS_CONTROL2, 32'h0);
		wr(vic_pkg::VIC_OFS_CONTROL1, 32'h20);
		pwm_mode_bit0 <= 1'b0;
		take(16'hfff2);
		t0 = t_load;
		take(16'hfff2);
		`CHK(t_load - t0, 64'(4 * vic_pkg::VIC_OSC_PERIOD))
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#60000;
		error_cnt++;
		give_verdict();
	end
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		events = 12'h000;
		pins = 3'b000;
		pwm_mode_bit0 = 1'b1;
		break_instruction = 1'b0;
		slow = 1'b0;
		rti = 1'b0;
		repeat (16) @(posedge sys_clk);
		t_reset();
		t_break();
		t_priority();
		t_edges();
		t_shared();
		t_periodic();
		give_verdict();
	end
endmodule // tb
bind vic_controller vic_monitor i_vic_monitor (.*);
